// ===== dv/dec_core_model.sv
// Core-side model: pipeline, load/store and reset report pulses
`default_nettype none
module dec_core_model (
  input  wire logic        clk,
  output var  logic        instr_done,
  output var  logic [29:0] instr_addr,
  output var  logic        branch_taken,
  output var  logic        exception,
  output var  logic        trap,
  output var  logic        uncond_event,
  output var  logic        data_valid,
  output var  logic        data_write,
  output var  logic [31:0] data_addr,
  output var  logic [31:0] data_value,
  output var  logic        reset_seen,
  output var  logic [1:0]  reset_kind
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {instr_done, branch_taken, exception, trap, uncond_event, data_valid} = 6'h00;
    {data_write, reset_seen, reset_kind, instr_addr, data_addr, data_value} = 98'h0;
  end
  // One cycle of conditions; released buses show the inverse of their last value
  task automatic fire(input logic [5:0] k, input logic [29:0] ia, input logic [31:0] da,
                      input logic [31:0] dv, input logic w);
    {instr_done, branch_taken, exception, trap, uncond_event, data_valid} <= k;
    instr_addr <= ia;
    data_addr  <= da;
    data_value <= dv;
    data_write <= w;
    @(posedge clk);
    {instr_done, branch_taken, exception, trap, uncond_event, data_valid} <= 6'h00;
    instr_addr <= ~ia;
    data_addr  <= ~da;
    data_value <= ~dv;
  endtask : fire
  task automatic report(input logic [1:0] kind);
    reset_seen <= 1'b1;
    reset_kind <= kind;
    @(posedge clk);
    reset_seen <= 1'b0;
    reset_kind <= ~kind;
  endtask : report
endmodule : dec_core_model
`default_nettype wire

// ===== dv/dec_debug_event_monitor.sv
// Port checker for the debug event compare unit
`default_nettype none
module dec_debug_event_monitor (
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic [9:0]  SPR_ADDR,
  input wire logic        SPR_WR,
  input wire logic [31:0] SPR_WDATA,
  input wire logic        INSTR_DONE,
  input wire logic        DEBUG_EXC_EN,
  input wire logic        BRANCH_TAKEN,
  input wire logic        EXCEPTION,
  input wire logic        TRAP,
  input wire logic        UNCOND_EVENT,
  input wire logic        DATA_VALID,
  input wire logic [1:0]  RESET_REQ,
  input wire logic        FREEZE_TIMERS,
  input wire logic        DEBUG_EVENT,
  input wire logic        EXT_DEBUG_MODE,
  input wire logic        INT_DEBUG_MODE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic ic_en_ff;
  logic ft_ff;
  wire  c0_wr  = SPR_WR && (SPR_ADDR == dec_pkg::SPR_CTRL_ZERO);
  wire  any_ev = INSTR_DONE | BRANCH_TAKEN | EXCEPTION | TRAP | UNCOND_EVENT | DATA_VALID;
  // Mirror of the completion and freeze enables
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ic_en_ff <= 1'b0;
      ft_ff    <= 1'b0;
    end else if (c0_wr) begin
      ic_en_ff <= SPR_WDATA[27];
      ft_ff    <= SPR_WDATA[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_ic_taken;
    INSTR_DONE && DEBUG_EXC_EN && ic_en_ff;
  endsequence
  property p_rst_req;
    c0_wr |=> RESET_REQ == $past(SPR_WDATA[29:28]);
  endproperty
  property p_rst_idle;
    !c0_wr |=> RESET_REQ == 2'h0;
  endproperty
  property p_mode_set;
    c0_wr |=> {EXT_DEBUG_MODE, INT_DEBUG_MODE} == $past(SPR_WDATA[31:30]);
  endproperty
  property p_mode_hold;
    !c0_wr |=> $stable({EXT_DEBUG_MODE, INT_DEBUG_MODE});
  endproperty
  property p_ic_event;
    s_ic_taken |=> DEBUG_EVENT;
  endproperty
  property p_idle;
    !any_ev |=> !DEBUG_EVENT;
  endproperty
  property p_exc_gate;
    !DEBUG_EXC_EN |=> !DEBUG_EVENT;
  endproperty
  property p_freeze_on;
    DEBUG_EVENT && ft_ff |=> FREEZE_TIMERS;
  endproperty
  property p_freeze_off;
    !ft_ff |=> !FREEZE_TIMERS;
  endproperty
  a_rst_req: assert property (p_rst_req) else $error("reset request wrong");
  a_rst_idle: assert property (p_rst_idle) else $error("stray reset request");
  a_mode_set: assert property (p_mode_set) else $error("debug mode wrong");
  a_mode_hold: assert property (p_mode_hold) else $error("debug mode moved");
  a_ic_event: assert property (p_ic_event) else $error("completion missed");
  a_idle: assert property (p_idle) else $error("event without cause");
  a_exc_gate: assert property (p_exc_gate) else $error("event while disabled");
  a_freeze_on: assert property (p_freeze_on) else $error("timers not frozen");
  a_freeze_off: assert property (p_freeze_off) else $error("timers frozen");
endmodule : dec_debug_event_monitor
bind dec_debug_event_unit dec_debug_event_monitor u_mon (
  .CLK_SYS(CLK_SYS), .RST(RST), .SPR_ADDR(SPR_ADDR), .SPR_WR(SPR_WR),
  .SPR_WDATA(SPR_WDATA), .INSTR_DONE(INSTR_DONE), .DEBUG_EXC_EN(DEBUG_EXC_EN),
  .BRANCH_TAKEN(BRANCH_TAKEN), .EXCEPTION(EXCEPTION), .TRAP(TRAP),
  .UNCOND_EVENT(UNCOND_EVENT), .DATA_VALID(DATA_VALID), .RESET_REQ(RESET_REQ),
  .FREEZE_TIMERS(FREEZE_TIMERS), .DEBUG_EVENT(DEBUG_EVENT),
  .EXT_DEBUG_MODE(EXT_DEBUG_MODE), .INT_DEBUG_MODE(INT_DEBUG_MODE)
);
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the debug event compare unit
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, s) begin \
    n_checks++; \
    if ((s) !== (e)) begin \
      errors++; \
      $display("CHECK FAILED %s exp %h got %h", n, e, s); \
    end \
  end
  logic        clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, dexc = 1'b0, ft = 1'b0;
  logic [9:0]  addr = 10'h000;
  logic [31:0] wdata = 32'h0, seed = 32'hAF0D, rdata, daddr, dval;
  logic        idone, bt, exc, trp, unc, dv, dw, rseen, fz, dev, external_debug_enable, internal_debug_enable;
  logic [29:0] iaddr;
  logic [1:0]  rkind, rreq;
  logic [31:0] dr[4] = '{32'hFFFFFFFF, 32'h0, 32'h40, 32'h41};
  int          fl[4] = '{24, 22, 23, 21};
  int          errors = 0;
  int          n_checks = 0;
  always #2.5 clk = ~clk;
  dec_debug_event_unit dut (
    .CLK_SYS(clk), .RST(rst), .SPR_ADDR(addr), .SPR_WR(wr_s), .SPR_RD(rd_s),
    .SPR_WDATA(wdata), .SPR_RDATA(rdata), .INSTR_DONE(idone), .INSTR_ADDR(iaddr),
    .BRANCH_TAKEN(bt), .EXCEPTION(exc), .TRAP(trp), .UNCOND_EVENT(unc),
    .DEBUG_EXC_EN(dexc), .DATA_VALID(dv), .DATA_WRITE(dw), .DATA_ADDR(daddr),
    .DATA_VALUE(dval), .RESET_SEEN(rseen), .RESET_KIND(rkind), .RESET_REQ(rreq),
    .FREEZE_TIMERS(fz), .DEBUG_EVENT(dev), .EXT_DEBUG_MODE(external_debug_enable), .INT_DEBUG_MODE(internal_debug_enable)
  );
  dec_core_model core (
    .clk(clk), .instr_done(idone), .instr_addr(iaddr), .branch_taken(bt), .exception(exc),
    .trap(trp), .uncond_event(unc), .data_valid(dv), .data_write(dw), .data_addr(daddr),
    .data_value(dval), .reset_seen(rseen), .reset_kind(rkind)
  );
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] lm(input logic [1:0] s);
    return (s == 2'h3) ? 32'h1F : (32'h1 << s) - 32'h1;
  endfunction : lm
  function automatic logic vm(input logic [1:0] m, input logic [3:0] be, input logic [3:0] eq);
    case (m)
      2'h1:    return &(~be | eq);
      2'h2:    return |(be & eq);
      2'h3:    return (&be[3:2] & &eq[3:2]) | (&be[1:0] & &eq[1:0]);
      default: return 1'b0;
    endcase
  endfunction : vm
  task automatic spr_w(input logic [9:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(negedge clk);
    if (a == 10'h3F2) `CHK("reset request", d[29:28], rreq)
    @(posedge clk);
  endtask : spr_w
  task automatic spr_r(input logic [9:0] a, input logic [31:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    `CHK($sformatf("spr %h", a), e, rdata)
    @(posedge clk);
  endtask : spr_r
  // Fires conditions, checks pulse, freeze and recorded flags, then clears status
  task automatic ev(input logic [5:0] k, input logic [29:0] ia, input logic [31:0] da,
                    input logic [31:0] dd, input logic w, input logic [31:0] st, input logic de);
    core.fire(k, ia, da, dd, w);
    @(negedge clk);
    `CHK("debug event", de, dev)
    @(negedge clk);
    `CHK("freeze", ft & (|st[31:19]), fz)
    @(posedge clk);
    spr_r(10'h3F0, st);
    spr_w(10'h3F0, 32'hFFFFFFFF);
    spr_r(10'h3F0, 32'h0);
  endtask : ev
  task automatic end_sim();
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    #200us;
    errors++;
    end_sim();
  end
  initial begin
    logic [31:0] v, lo, a, e, cv;
    logic [3:0]  be, eq;
    logic [1:0]  s, c;
    logic        hit, x;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    spr_r(10'h3F0, 32'h0);
    v = rnd();
    spr_w(10'h3F6, v);
    spr_w(10'h3F8, ~v);
    spr_r(10'h3F6, v);
    spr_r(10'h3F8, 32'h0);
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      spr_w(10'h3F2, {v[31:30], 2'(i), v[27:0]});
      spr_r(10'h3F2, {v[31:30], 2'h0, v[27:0]} & dec_pkg::CTRL_ZERO_MASK);
      `CHK("debug modes", v[31:30], {external_debug_enable, internal_debug_enable})
      spr_w(10'h3BD, v);
      spr_r(10'h3BD, v & dec_pkg::CTRL_ONE_MASK);
    end
    spr_w(10'h3BD, 32'h0);
    ft = 1'b1;
    for (int d = 1; d >= 0; d--) begin
      dexc <= 1'(d);
      for (int j = 0; j < 5; j++) begin
        spr_w(10'h3F2, 32'h1 | ((j < 4) ? 32'h1 << (27 - j) : 32'h0));
        e = (32'h1 << (31 - j)) | (d ? 32'h0 : 32'h00100000);
        ev(6'h20 >> j, 30'h0, 32'h0, 32'h0, 1'b0, e, 1'(d));
      end
    end
    ft = 1'b0;
    spr_w(10'h3F2, 32'h0);
    for (int k = 1; k < 4; k++) begin
      core.report(2'(k));
      spr_r(10'h3F0, 32'(k) << 8);
      spr_w(10'h3F0, 32'h300);
    end
    for (int i = 0; i < 16; i++) begin
      v = rnd();
      s = 2'(i >> 2);
      c = v[1:0];
      lo = rnd();
      a = lo ^ (rnd() & (v[4] ? lm(s) : 32'h3F));
      hit = (((a ^ lo) & ~lm(s)) == 32'h0) && (v[5] == c[1]);
      spr_w(10'h3F6, lo);
      spr_w(10'h3F7, lo);
      spr_w(10'h3BD, (32'h80000000 >> c) | {4'h0, s, s, 24'h0});
      e = hit ? (32'h00100000 | (32'h1 << fl[c])) : 32'h0;
      ev(6'h01, 30'h0, a, rnd(), v[5], e, 1'b0);
    end
    for (int i = 0; i < 10; i++) begin
      x = i[0];
      lo = (rnd() & 32'h0FFFFF00) | 32'h100;
      a = lo + ((i < 8) ? dr[i >> 1] : rnd() & 32'h3F);
      hit = ((a >= lo) && (a <= lo + 32'h40)) ^ x;
      spr_w(10'h3F6, lo);
      spr_w(10'h3F7, lo + 32'h40);
      spr_w(10'h3BD, {9'h101, x, 22'h0});
      ev(6'h01, 30'h0, a, rnd(), 1'b0, hit ? 32'h01100000 : 32'h0, 1'b0);
    end
    for (int i = 0; i < 16; i++) begin
      v = rnd();
      lo = rnd();
      cv = rnd();
      be = (i[1:0] == 2'h3) ? 4'hF : ((v[3:0] != 4'h0) ? v[3:0] : 4'h8);
      eq = (i < 4) ? 4'hF : v[11:8];
      spr_w(10'h3F6, lo);
      spr_w(dec_pkg::SPR_VAL_ONE, cv);
      spr_w(10'h3BD, 32'h80000000 | {12'h0, i[1:0], 2'h0, be, 12'h0});
      a = cv ^ ({{8{!eq[3]}}, {8{!eq[2]}}, {8{!eq[1]}}, {8{!eq[0]}}} & 32'hA5A5A5A5);
      e = vm(i[1:0], be, eq) ? 32'h01100000 : 32'h0;
      ev(6'h01, 30'h0, lo, a, 1'b0, e, 1'b0);
    end
    for (int p = 0; p < 2; p++) begin
      lo = (rnd() & 32'h0FFFFF00) | 32'h100;
      spr_w(p ? dec_pkg::SPR_IADDR_THREE : dec_pkg::SPR_IADDR_ONE, lo << 2);
      spr_w(p ? dec_pkg::SPR_IADDR_FOUR : dec_pkg::SPR_IADDR_TWO, (lo + 32'h40) << 2);
      for (int i = 0; i < 6; i++) begin
        x = i[0];
        v = p ? (32'h000A4000 | (32'(x) << 16)) : (32'h00A08000 | (32'(x) << 20));
        spr_w(10'h3F2, v);
        a = lo + ((i < 4) ? dr[i] : rnd() & 32'h7F);
        hit = ((a >= lo) && (a <= lo + 32'h40)) ^ x;
        e = hit ? (32'h00100000 | (p ? 32'h00080000 : 32'h04000000)) : 32'h0;
        ev(6'h20, a[29:0], 32'h0, 32'h0, 1'b0, e, 1'b0);
        e = hit ? (p ? 32'h00010000 : 32'h00100000) : 32'h0;
        spr_r(10'h3F2, v ^ e);
      end
    end
    for (int q = 0; q < 4; q++) begin
      v = rnd() & dec_pkg::IADDR_MASK;
      spr_w(q[1] ? 10'h3B4 + 10'(q[0]) : 10'h3F4 + 10'(q[0]), v);
      spr_w(10'h3F2, 32'h1 << (q[1] ? 19 - q[0] : 23 - q[0]));
      e = 32'h00100000 | (32'h1 << (q[1] ? 19 - q[0] : 26 - q[0]));
      ev(6'h20, v[31:2], 32'h0, 32'h0, 1'b0, e, 1'b0);
    end
    end_sim();
  end
endmodule : tb
`default_nettype wire

// ===== hdl/dec_debug_event_unit.sv
// Debug event compare unit: control/status SPRs, address and value compares, event recording
//
// Operation
// - Nonzero reset field write issues reset request
// - Instr compares one-two form range when enabled
// - Range one-two inclusive or exclusive select
// - Instr compares three-four range, own exclusive select
// - Toggle bits invert exclusive select per event
// - Freeze timers on debug event when enabled
// - Per-event enables for instruction-side events
// - External and internal debug mode enables
// - Read/write event enables for both data compares
// - Size field ignores 0,1,2 or 5 bits
// - Data compares one-two form range when enabled
// - Data range inclusive or exclusive select
// - AND mode: all enabled bytes equal
// - OR mode: any enabled byte equal
// - AND-OR mode: upper or lower halfword equal
// - Byte enables choose bytes per value compare
// - Status flag recorded for every occurred event
// - Imprecise flag when debug exceptions disabled
// - Data compare registers hold full byte address
// - Status records most recent reset kind
`default_nettype none
module dec_debug_event_unit (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // Register port (SPR access from the core)
  input  wire logic [9:0]  SPR_ADDR,
  input  wire logic        SPR_WR,
  input  wire logic        SPR_RD,
  input  wire logic [31:0] SPR_WDATA,
  output var  logic [31:0] SPR_RDATA,
  // Event conditions from the pipeline
  input  wire logic        INSTR_DONE,
  input  wire logic [29:0] INSTR_ADDR,
  input  wire logic        BRANCH_TAKEN,
  input  wire logic        EXCEPTION,
  input  wire logic        TRAP,
  input  wire logic        UNCOND_EVENT,
  input  wire logic        DEBUG_EXC_EN,
  // Load/store access
  input  wire logic        DATA_VALID,
  input  wire logic        DATA_WRITE,
  input  wire logic [31:0] DATA_ADDR,
  input  wire logic [31:0] DATA_VALUE,
  // Reset report after a reset has taken place
  input  wire logic        RESET_SEEN,
  input  wire logic [1:0]  RESET_KIND,
  // Outputs to the core
  output var  logic [1:0]  RESET_REQ,
  output var  logic        FREEZE_TIMERS,
  output var  logic        DEBUG_EVENT,
  output var  logic        EXT_DEBUG_MODE,
  output var  logic        INT_DEBUG_MODE
);

  ////////////////////////////////////////////////////////////////////////////////
  // Compare helpers

  // Size field to mask: 0, 1, 2 or 5 low bits ignored
  function automatic logic [31:0] size_mask(input logic [1:0] sz);
    logic [31:0] m;
    m = 32'hFFFFFFE0;
    if (sz == dec_pkg::SIZE_BYTE) begin
      m = 32'hFFFFFFFF;
    end else if (sz == dec_pkg::SIZE_HALF) begin
      m = 32'hFFFFFFFE;
    end else if (sz == dec_pkg::SIZE_WORD) begin
      m = 32'hFFFFFFFC;
    end
    return m;
  endfunction : size_mask

  // Byte enable bit 3 covers the most significant data byte
  // Zero enables leave the address compare alone
  // Mode zero never matches when any byte enable is set
  function automatic logic value_match(input logic [31:0] d, input logic [31:0] v,
                                       input logic [3:0] be, input logic [1:0] md);
    logic [3:0] eq;
    logic       hi;
    logic       lo;
    logic       r;
    for (int i = 0; i < 4; i++) begin
      eq[i] = (d[i*8 +: 8] == v[i*8 +: 8]);
    end
    hi = (|be[3:2]) & (&(eq[3:2] | ~be[3:2]));
    lo = (|be[1:0]) & (&(eq[1:0] | ~be[1:0]));
    r  = 1'b0;
    if (be == 4'h0) begin
      r = 1'b1;
    end else if (md == dec_pkg::MODE_AND) begin
      r = &(eq | ~be);
    end else if (md == dec_pkg::MODE_OR) begin
      r = |(eq & be);
    end else if (md == dec_pkg::MODE_ANDOR) begin
      r = hi | lo;
    end
    return r;
  endfunction : value_match

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0] ctrl_zero_ff;
  logic [31:0] ctrl_one_ff;
  logic [31:0] status_ff;
  logic [31:0] daddr_ff [2];
  logic [31:0] val_ff   [2];
  logic [31:0] iaddr_ff [4];
  logic [31:0] nxt_ctrl_zero;
  logic [31:0] nxt_status;
  logic [1:0]  reset_req_ff;
  logic        freeze_ff;
  logic        event_ff;
  logic [31:0] rdata_ff;

  wire logic wr_ctrl_zero = SPR_WR & (SPR_ADDR == dec_pkg::SPR_CTRL_ZERO);
  wire logic wr_ctrl_one  = SPR_WR & (SPR_ADDR == dec_pkg::SPR_CTRL_ONE);
  wire logic wr_status    = SPR_WR & (SPR_ADDR == dec_pkg::SPR_STATUS);
  wire logic [1:0] wr_daddr = {SPR_WR & (SPR_ADDR == dec_pkg::SPR_DADDR_TWO),
                               SPR_WR & (SPR_ADDR == dec_pkg::SPR_DADDR_ONE)};
  wire logic [1:0] wr_val   = {SPR_WR & (SPR_ADDR == dec_pkg::SPR_VAL_TWO),
                               SPR_WR & (SPR_ADDR == dec_pkg::SPR_VAL_ONE)};
  wire logic [3:0] wr_iaddr = {SPR_WR & (SPR_ADDR == dec_pkg::SPR_IADDR_FOUR),
                               SPR_WR & (SPR_ADDR == dec_pkg::SPR_IADDR_THREE),
                               SPR_WR & (SPR_ADDR == dec_pkg::SPR_IADDR_TWO),
                               SPR_WR & (SPR_ADDR == dec_pkg::SPR_IADDR_ONE)};

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction address compares

  // Low two bits are kept zero: word addresses
  wire logic [29:0] ia1 = iaddr_ff[0][31:2];
  wire logic [29:0] ia2 = iaddr_ff[1][31:2];
  wire logic [29:0] ia3 = iaddr_ff[2][31:2];
  wire logic [29:0] ia4 = iaddr_ff[3][31:2];

  // Both ends included; exclusive inverts
  wire logic in_range_a = (INSTR_ADDR >= ia1) & (INSTR_ADDR <= ia2);
  wire logic in_range_b = (INSTR_ADDR >= ia3) & (INSTR_ADDR <= ia4);
  wire logic hit_range_a = in_range_a ^ ctrl_zero_ff[dec_pkg::C0_RA_X];
  wire logic hit_range_b = in_range_b ^ ctrl_zero_ff[dec_pkg::C0_RB_X];
  wire logic range_a_on  = ctrl_zero_ff[dec_pkg::C0_RA_EN];
  wire logic range_b_on  = ctrl_zero_ff[dec_pkg::C0_RB_EN];

  // Range mode replaces the two single-address compares of the pair
  wire logic [3:0] ia_hit = {range_b_on ? hit_range_b : (INSTR_ADDR == ia4),
                             range_b_on ? hit_range_b : (INSTR_ADDR == ia3),
                             range_a_on ? hit_range_a : (INSTR_ADDR == ia2),
                             range_a_on ? hit_range_a : (INSTR_ADDR == ia1)};
  wire logic [3:0] ia_en  = {ctrl_zero_ff[dec_pkg::C0_IA4], ctrl_zero_ff[dec_pkg::C0_IA3],
                             ctrl_zero_ff[dec_pkg::C0_IA2], ctrl_zero_ff[dec_pkg::C0_IA1]};
  wire logic [3:0] ia_ev  = ia_hit & ia_en & {4{INSTR_DONE}};

  ////////////////////////////////////////////////////////////////////////////////
  // Data address and value compares

  wire logic [1:0] d_size [2];
  wire logic [1:0] v_mode [2];
  wire logic [3:0] v_bytes [2];
  wire logic [1:0] d_rd_en;
  wire logic [1:0] d_wr_en;
  wire logic [1:0] d_rd_ev;
  wire logic [1:0] d_wr_ev;

  assign d_size[0]  = ctrl_one_ff[dec_pkg::C1_D1S_HI -: 2];
  assign d_size[1]  = ctrl_one_ff[dec_pkg::C1_D2S_HI -: 2];
  assign v_mode[0]  = ctrl_one_ff[dec_pkg::C1_V1M_HI -: 2];
  assign v_mode[1]  = ctrl_one_ff[dec_pkg::C1_V2M_HI -: 2];
  assign v_bytes[0] = ctrl_one_ff[dec_pkg::C1_V1B_HI -: 4];
  assign v_bytes[1] = ctrl_one_ff[dec_pkg::C1_V2B_HI -: 4];
  assign d_rd_en    = {ctrl_one_ff[dec_pkg::C1_D2R], ctrl_one_ff[dec_pkg::C1_D1R]};
  assign d_wr_en    = {ctrl_one_ff[dec_pkg::C1_D2W], ctrl_one_ff[dec_pkg::C1_D1W]};

  wire logic d_in_range = (DATA_ADDR >= daddr_ff[0]) & (DATA_ADDR <= daddr_ff[1]);
  wire logic d_hit_range = d_in_range ^ ctrl_one_ff[dec_pkg::C1_DR_X];
  wire logic d_range_on  = ctrl_one_ff[dec_pkg::C1_DR_EN];

  for (genvar g = 0; g < 2; g++) begin : g_dcmp
    wire logic [31:0] m = size_mask(d_size[g]);
    wire logic a_eq = ((DATA_ADDR & m) == (daddr_ff[g] & m));
    wire logic a_hit = d_range_on ? d_hit_range : a_eq;
    wire logic v_hit = value_match(DATA_VALUE, val_ff[g], v_bytes[g], v_mode[g]);
    assign d_rd_ev[g] = DATA_VALID & ~DATA_WRITE & d_rd_en[g] & a_hit & v_hit;
    assign d_wr_ev[g] = DATA_VALID & DATA_WRITE & d_wr_en[g] & a_hit & v_hit;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event collection and status update

  // One bit per event source
  logic [31:0] ev_set;

  always_comb begin
    ev_set = 32'h00000000;
    ev_set[dec_pkg::ST_IC]   = INSTR_DONE & ctrl_zero_ff[dec_pkg::C0_IC];
    ev_set[dec_pkg::ST_BT]   = BRANCH_TAKEN & ctrl_zero_ff[dec_pkg::C0_BT];
    ev_set[dec_pkg::ST_EXC]  = EXCEPTION & ctrl_zero_ff[dec_pkg::C0_EXC];
    ev_set[dec_pkg::ST_TRAP] = TRAP & ctrl_zero_ff[dec_pkg::C0_TRAP];
    // Unconditional events need no enable
    ev_set[dec_pkg::ST_UNC]  = UNCOND_EVENT;
    ev_set[dec_pkg::ST_IA1]  = ia_ev[0];
    ev_set[dec_pkg::ST_IA2]  = ia_ev[1];
    ev_set[dec_pkg::ST_IA3]  = ia_ev[2];
    ev_set[dec_pkg::ST_IA4]  = ia_ev[3];
    ev_set[dec_pkg::ST_DR1]  = d_rd_ev[0];
    ev_set[dec_pkg::ST_DW1]  = d_wr_ev[0];
    ev_set[dec_pkg::ST_DR2]  = d_rd_ev[1];
    ev_set[dec_pkg::ST_DW2]  = d_wr_ev[1];
  end

  wire logic any_event = |ev_set;
  // Write one to clear, reserved bits ignored
  wire logic [31:0] st_clr = wr_status ? (SPR_WDATA & dec_pkg::STATUS_MASK) : 32'h00000000;

  always_comb begin
    // Hardware sets win over a software clear in the same cycle
    nxt_status = status_ff & ~st_clr;
    nxt_status = nxt_status | ev_set;
    if (any_event & ~DEBUG_EXC_EN) begin
      nxt_status[dec_pkg::ST_IMP] = 1'b1;
    end
    if (RESET_SEEN) begin
      nxt_status[dec_pkg::ST_MRR_HI -: 2] = RESET_KIND;
    end
  end

  // A control write wins over the toggle
  always_comb begin
    nxt_ctrl_zero = ctrl_zero_ff;
    if (wr_ctrl_zero) begin
      nxt_ctrl_zero = SPR_WDATA & dec_pkg::CTRL_ZERO_MASK;
    end else if (any_event) begin
      nxt_ctrl_zero[dec_pkg::C0_RA_X] = ctrl_zero_ff[dec_pkg::C0_RA_X] ^
                                        ctrl_zero_ff[dec_pkg::C0_RA_T];
      nxt_ctrl_zero[dec_pkg::C0_RB_X] = ctrl_zero_ff[dec_pkg::C0_RB_X] ^
                                        ctrl_zero_ff[dec_pkg::C0_RB_T];
    end
  end

  // Freeze follows any recorded event flag
  wire logic [31:0] event_flags = status_ff & ~32'h000003FF;
  // Reset field is not stored: one-cycle pulse
  wire logic nxt_freeze = ctrl_zero_ff[dec_pkg::C0_FT] & (|event_flags);
  wire logic [1:0] nxt_reset_req = wr_ctrl_zero ? SPR_WDATA[dec_pkg::C0_RST_HI -: 2] : 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux

  // Reads see state before a same-cycle write
  logic [31:0] rd_mux;

  always_comb begin
    unique case (SPR_ADDR)
      dec_pkg::SPR_CTRL_ZERO:   rd_mux = ctrl_zero_ff;
      dec_pkg::SPR_CTRL_ONE:    rd_mux = ctrl_one_ff;
      dec_pkg::SPR_STATUS:      rd_mux = status_ff;
      dec_pkg::SPR_DADDR_ONE:   rd_mux = daddr_ff[0];
      dec_pkg::SPR_DADDR_TWO:   rd_mux = daddr_ff[1];
      dec_pkg::SPR_VAL_ONE:     rd_mux = val_ff[0];
      dec_pkg::SPR_VAL_TWO:     rd_mux = val_ff[1];
      dec_pkg::SPR_IADDR_ONE:   rd_mux = iaddr_ff[0];
      dec_pkg::SPR_IADDR_TWO:   rd_mux = iaddr_ff[1];
      dec_pkg::SPR_IADDR_THREE: rd_mux = iaddr_ff[2];
      dec_pkg::SPR_IADDR_FOUR:  rd_mux = iaddr_ff[3];
      default:                  rd_mux = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flip-flops

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl_zero_ff <= dec_pkg::REG_RESET;
      ctrl_one_ff  <= dec_pkg::REG_RESET;
      status_ff    <= dec_pkg::REG_RESET;
    end else begin
      ctrl_zero_ff <= nxt_ctrl_zero;
      status_ff    <= nxt_status;
      if (wr_ctrl_one) begin
        ctrl_one_ff <= SPR_WDATA & dec_pkg::CTRL_ONE_MASK;
      end
    end
  end

  // Data compare registers keep all bits
  for (genvar g = 0; g < 2; g++) begin : g_dregs
    always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
        daddr_ff[g] <= dec_pkg::REG_RESET;
        val_ff[g]   <= dec_pkg::REG_RESET;
      end else begin
        if (wr_daddr[g]) begin
          daddr_ff[g] <= SPR_WDATA;
        end
        if (wr_val[g]) begin
          val_ff[g] <= SPR_WDATA;
        end
      end
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_iregs
    always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
        iaddr_ff[g] <= dec_pkg::REG_RESET;
      end else if (wr_iaddr[g]) begin
        iaddr_ff[g] <= SPR_WDATA & dec_pkg::IADDR_MASK;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      // Event pulse only with debug exceptions on
      reset_req_ff <= 2'h0;
      freeze_ff    <= 1'b0;
      event_ff     <= 1'b0;
      rdata_ff     <= 32'h00000000;
    end else begin
      reset_req_ff <= nxt_reset_req;
      freeze_ff    <= nxt_freeze;
      event_ff     <= any_event & DEBUG_EXC_EN;
      if (SPR_RD) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  assign SPR_RDATA      = rdata_ff;
  assign RESET_REQ      = reset_req_ff;
  assign FREEZE_TIMERS  = freeze_ff;
  assign DEBUG_EVENT    = event_ff;
  assign EXT_DEBUG_MODE = ctrl_zero_ff[dec_pkg::C0_EXT];
  assign INT_DEBUG_MODE = ctrl_zero_ff[dec_pkg::C0_INT];

endmodule : dec_debug_event_unit
`default_nettype wire

// ===== hdl/dec_pkg.sv
// Constants shared by the debug event compare unit: SPR numbers, field positions, masks
`default_nettype none
package dec_pkg;

  // SPR numbers of the registers held by this unit
  localparam logic [9:0]  SPR_CTRL_ONE    = 10'h3BD;
  localparam logic [9:0]  SPR_STATUS      = 10'h3F0;
  localparam logic [9:0]  SPR_CTRL_ZERO   = 10'h3F2;
  localparam logic [9:0]  SPR_DADDR_ONE   = 10'h3F6;
  localparam logic [9:0]  SPR_DADDR_TWO   = 10'h3F7;
  localparam logic [9:0]  SPR_VAL_ONE     = 10'h3B6;
  localparam logic [9:0]  SPR_VAL_TWO     = 10'h3B7;
  localparam logic [9:0]  SPR_IADDR_ONE   = 10'h3F4;
  localparam logic [9:0]  SPR_IADDR_TWO   = 10'h3F5;
  localparam logic [9:0]  SPR_IADDR_THREE = 10'h3B4;
  localparam logic [9:0]  SPR_IADDR_FOUR  = 10'h3B5;

  // Writable bits; everything else reads zero
  localparam logic [31:0] CTRL_ZERO_MASK  = 32'hCFFFC001;
  localparam logic [31:0] CTRL_ONE_MASK   = 32'hFFCFFF00;
  localparam logic [31:0] STATUS_MASK     = 32'hFFFC0300;
  localparam logic [31:0] IADDR_MASK      = 32'hFFFFFFFC;
  localparam logic [31:0] REG_RESET       = 32'h00000000;

  // Bit positions: MSB-0 bit n sits at vector index 31-n
  localparam int C0_EXT    = 31;
  localparam int C0_INT    = 30;
  localparam int C0_RST_HI = 29;
  localparam int C0_IC     = 27;
  localparam int C0_BT     = 26;
  localparam int C0_EXC    = 25;
  localparam int C0_TRAP   = 24;
  localparam int C0_IA1    = 23;
  localparam int C0_IA2    = 22;
  localparam int C0_RA_EN  = 21;
  localparam int C0_RA_X   = 20;
  localparam int C0_IA3    = 19;
  localparam int C0_IA4    = 18;
  localparam int C0_RB_EN  = 17;
  localparam int C0_RB_X   = 16;
  localparam int C0_RA_T   = 15;
  localparam int C0_RB_T   = 14;
  localparam int C0_FT     = 0;

  localparam int C1_D1R    = 31;
  localparam int C1_D2R    = 30;
  localparam int C1_D1W    = 29;
  localparam int C1_D2W    = 28;
  localparam int C1_D1S_HI = 27;
  localparam int C1_D2S_HI = 25;
  localparam int C1_DR_EN  = 23;
  localparam int C1_DR_X   = 22;
  localparam int C1_V1M_HI = 19;
  localparam int C1_V2M_HI = 17;
  localparam int C1_V1B_HI = 15;
  localparam int C1_V2B_HI = 11;

  localparam int ST_IC     = 31;
  localparam int ST_BT     = 30;
  localparam int ST_EXC    = 29;
  localparam int ST_TRAP   = 28;
  localparam int ST_UNC    = 27;
  localparam int ST_IA1    = 26;
  localparam int ST_IA2    = 25;
  localparam int ST_DR1    = 24;
  localparam int ST_DW1    = 23;
  localparam int ST_DR2    = 22;
  localparam int ST_DW2    = 21;
  localparam int ST_IMP    = 20;
  localparam int ST_IA3    = 19;
  localparam int ST_IA4    = 18;
  localparam int ST_MRR_HI = 9;

  // Size and mode encodings
  localparam logic [1:0]  SIZE_BYTE  = 2'h0;
  localparam logic [1:0]  SIZE_HALF  = 2'h1;
  localparam logic [1:0]  SIZE_WORD  = 2'h2;
  localparam logic [1:0]  MODE_AND   = 2'h1;
  localparam logic [1:0]  MODE_OR    = 2'h2;
  localparam logic [1:0]  MODE_ANDOR = 2'h3;

endpackage : dec_pkg
`default_nettype wire
